// [design/gpa_params.svh]
`ifndef GPA_PARAMS_SVH
`define GPA_PARAMS_SVH

// Register index on the plain register port
`define GPA_ADDR_W      3
`define GPA_OFS_LEVEL   3'h0
`define GPA_OFS_LATCH   3'h1
`define GPA_OFS_DIR     3'h2
`define GPA_OFS_ANALOG_SELECT_REG   3'h3
`define GPA_OFS_PCTL    3'h4

// Reset values
`define GPA_RST_LAT     8'h00
`define GPA_RST_DIR     8'hff
`define GPA_RST_ANS     5'h1f
`define GPA_RST_PCTL    3'h0
`define GPA_RST_DIV     2'h0

// Peripheral control field positions
`define GPA_PCTL_C1OE   0
`define GPA_PCTL_C2OE   1
`define GPA_PCTL_CVROE  2

// Analog select bit that serves pin five
`define GPA_ANS_PIN5    4

// Pin positions of the shared functions
`define GPA_PIN_COMPARATOR_REF_VOLTAGE_OUT   2
`define GPA_PIN_T0CK    4
`define GPA_PIN_SS      5
`define GPA_PIN_OSC2    6
`define GPA_PIN_OSC1    7

// Clock out divider: two-bit counter, output is its top bit (Fosc/4)
`define GPA_CLKOUT_BIT  1

`endif

// [design/gpa_pkg.sv]
package gpa_pkg;

  // Oscillator selections from the configuration word
  typedef enum logic [3:0] {
    GPA_OSC_LP      = 4'h0,
    GPA_OSC_XT      = 4'h1,
    GPA_OSC_HS      = 4'h2,
    GPA_OSC_RC      = 4'h3,
    GPA_OSC_RC_OSC_WITH_IO_MODE    = 4'h4,
    GPA_OSC_INTCK   = 4'h5,
    GPA_OSC_INTIO   = 4'h6,
    GPA_OSC_EXTCK   = 4'h7,
    GPA_OSC_EXTIO   = 4'h8
  } gpa_osc_mode_t;

  // Whole state of the port block
  typedef struct packed {
    logic [7:0]    lat;
    logic [7:0]    dir;
    logic [4:0]    ans;
    logic [2:0]    pctl;
    gpa_osc_mode_t osc;
    logic          cfg_done;
    logic [1:0]    div;
    logic [7:0]    pad_out;
    logic [7:0]    pad_oe_n;
    logic [7:0]    rdata;
    logic          t0ck;
    logic          ss_n;
  } gpa_state_t;

endpackage

// [design/gpa_sync.sv]
`timescale 1ns/10ps
module gpa_sync #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gpa_sync_st_t;

  gpa_sync_st_t st_q;
  gpa_sync_st_t st_d;

  // First stage feeds only the second one, to settle metastability
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign dout = st_q.s2;
endmodule // gpa_sync

// [design/gpa_pin_cell.sv]
`timescale 1ns/10ps
module gpa_pin_cell (
  input  wire logic dir,
  input  wire logic lat,
  input  wire logic io_en,
  input  wire logic ana_sel,
  input  wire logic alt_en,
  input  wire logic alt_force,
  input  wire logic alt_val,
  input  wire logic kill,
  input  wire logic sync_in,
  output logic      drive_d,
  output logic      oe_n_d,
  output logic      level_rd
);
  // Output side: peripheral overrides come before plain port data
  always_comb
  begin
    drive_d = 1'b0;
    oe_n_d  = 1'b1;
    if (kill || (!io_en && !alt_force))
    begin
      drive_d = 1'b0;
      oe_n_d  = 1'b1;
    end
    else if (alt_force)
    begin
      drive_d = alt_val;
      oe_n_d  = 1'b0;
    end
    else
    begin
      oe_n_d  = dir;
      drive_d = (alt_en && !dir) ? alt_val : lat;
    end
  end

  // Input side: analog select or reference output blank the reading
  assign level_rd = io_en && !ana_sel && !kill && sync_in;
endmodule // gpa_pin_cell

// [design/gpa_port.sv]
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "gpa_params.svh"
// Function
// R1: Direction bit 1 makes the pin an input, driver off.
// R2: Direction bit 0 drives the pin from its latch bit.
// R3: Pin-level read returns pins; pin-level write goes to the latch.
// R4: Latch register reads back latched data for read-modify-write.
// R5: Eight pins, each with direction, latch and pin-level bit.
// R6: Bits six and seven read zero everywhere when oscillator owns them.
// R7: Five analog-select bits for pins 0-3 and 5, all analog after reset.
// R8: Analog pins read zero after reset; pin four starts digital input.
// R9: Analog select blocks digital input; output still follows direction. Only the pin-level read is blanked; slave select still sees analog pin five.
// R10: Software keeps direction set to input on analog pins.
// R11: Enabled comparator output overrides latch on pins four/five when output.
// R12: Reference voltage output on pin two kills digital in and out.
// R13: Pin six is port I/O only in the three with-I/O oscillator modes.
// R14: Pin six outputs Fosc/4 in the three clock-out modes.
// R15: An enabled shared peripheral takes the pin from port use.
// R16: Pin four as input feeds the timer0 external clock.
// R17: Pin five as input feeds the serial port slave select.
// R18: This block is one of up to five such ports.
// R19: Pin seven is port I/O only when no external oscillator uses it.
// R20: Pin levels are synchronised before the pin-level read path.
module gpa_port (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire logic [`GPA_ADDR_W-1:0]      reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  input  wire gpa_pkg::gpa_osc_mode_t      osc_cfg,
  input  wire logic                        comparator_one_output,
  input  wire logic                        comparator_two_output,
  input  wire logic [7:0]                  pad_in,
  output logic      [7:0]                  pad_out,
  output logic      [7:0]                  pad_oe_n,
  output logic                             timer0_ext_clock_in,
  output logic                             ssp_select_n
);
  import gpa_pkg::*;

  gpa_state_t st_q;
  gpa_state_t st_d;
  logic [7:0] pin_sync;
  logic [7:0] io_en;
  logic [7:0] ana_pin;
  logic [7:0] alt_en;
  logic [7:0] alt_force;
  logic [7:0] alt_val;
  logic [7:0] kill;
  logic [7:0] drive_d;
  logic [7:0] oe_n_d;
  logic [7:0] level_rd;
  logic       io6;
  logic       io7;
  logic       clkout6;
  logic [7:0] osc_mask;

  // Pins cross into the clock domain before anyone reads them
  gpa_sync #(
    .W (8)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     (pad_in),
    .dout    (pin_sync)          // [R20]
  );

  // Oscillator selection decides who owns pins six and seven
  always_comb
  begin
    io6     = (st_q.osc == GPA_OSC_RC_OSC_WITH_IO_MODE) || (st_q.osc == GPA_OSC_INTIO) ||
              (st_q.osc == GPA_OSC_EXTIO);                      // [R13]
    clkout6 = (st_q.osc == GPA_OSC_RC) || (st_q.osc == GPA_OSC_INTCK) ||
              (st_q.osc == GPA_OSC_EXTCK);                      // [R14]
    io7     = (st_q.osc == GPA_OSC_INTIO) ||
              (st_q.osc == GPA_OSC_INTCK);                      // [R19]
  end

  // Per-pin enables and peripheral overrides
  always_comb
  begin
    io_en      = {io7, io6, 6'h3f};
    osc_mask   = {io7, io6, 6'h3f};                             // [R6]
    ana_pin    = {2'h0, st_q.ans[`GPA_ANS_PIN5], 1'b0,
                  st_q.ans[3:0]};                               // [R7]
    alt_en     = 8'h00;
    alt_force  = 8'h00;
    alt_val    = 8'h00;
    kill       = 8'h00;
    // Comparator outputs win over latch data when enabled [R11] [R15]
    alt_en[`GPA_PIN_T0CK]   = st_q.pctl[`GPA_PCTL_C1OE];
    alt_val[`GPA_PIN_T0CK]  = comparator_one_output;
    alt_en[`GPA_PIN_SS]     = st_q.pctl[`GPA_PCTL_C2OE];
    alt_val[`GPA_PIN_SS]    = comparator_two_output;
    // Clock out ignores the direction bit entirely [R14]
    alt_force[`GPA_PIN_OSC2] = clkout6;
    alt_val[`GPA_PIN_OSC2]   = st_q.div[`GPA_CLKOUT_BIT];
    // Reference output is analog; digital buffers must let go [R12]
    kill[`GPA_PIN_COMPARATOR_REF_VOLTAGE_OUT]     = st_q.pctl[`GPA_PCTL_CVROE];
  end

  // One cell per pin; the direction bit still steers analog pins [R10]
  for (genvar i = 0; i < 8; i++)
  begin : g_pin
    gpa_pin_cell u_cell (
      .dir       (st_q.dir[i]),
      .lat       (st_q.lat[i]),
      .io_en     (io_en[i]),
      .ana_sel   (ana_pin[i]),
      .alt_en    (alt_en[i]),
      .alt_force (alt_force[i]),
      .alt_val   (alt_val[i]),
      .kill      (kill[i]),
      .sync_in   (pin_sync[i]),
      .drive_d   (drive_d[i]),
      .oe_n_d    (oe_n_d[i]),
      .level_rd  (level_rd[i])
    );
  end

  // Next state: config capture, register writes, reads, pin outputs
  always_comb
  begin
    st_d = st_q;
    // Oscillator straps are taken once, on the first edge after reset
    if (!st_q.cfg_done)
    begin
      st_d.osc      = osc_cfg;
      st_d.cfg_done = 1'b1;
    end
    st_d.div = st_q.div + 2'h1;                                 // [R14]
    // This port's own register set, one of several identical ports [R18]
    if (reg_wr)
    begin
      unique case (reg_addr)
        `GPA_OFS_LEVEL: st_d.lat  = reg_wdata;                  // [R3]
        `GPA_OFS_LATCH: st_d.lat  = reg_wdata;                  // [R4]
        `GPA_OFS_DIR:   st_d.dir  = reg_wdata;                  // [R5]
        `GPA_OFS_ANALOG_SELECT_REG: st_d.ans  = reg_wdata[4:0];             // [R7]
        `GPA_OFS_PCTL:  st_d.pctl = reg_wdata[2:0];
        default:        st_d.lat  = st_q.lat;
      endcase
    end
    // Read data stand for the one cycle after the strobe only
    st_d.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `GPA_OFS_LEVEL: st_d.rdata = level_rd & osc_mask;       // [R3] [R9]
        `GPA_OFS_LATCH: st_d.rdata = st_q.lat & osc_mask;       // [R4] [R6]
        `GPA_OFS_DIR:   st_d.rdata = st_q.dir & osc_mask;       // [R6]
        `GPA_OFS_ANALOG_SELECT_REG: st_d.rdata = {3'h0, st_q.ans};
        `GPA_OFS_PCTL:  st_d.rdata = {5'h00, st_q.pctl};
        default:        st_d.rdata = 8'h00;
      endcase
    end
    st_d.pad_out  = drive_d;                                    // [R2]
    st_d.pad_oe_n = oe_n_d;                                     // [R1]
    // Timer0 and slave select only see the pin while it is an input
    st_d.t0ck = st_q.dir[`GPA_PIN_T0CK] &
                pin_sync[`GPA_PIN_T0CK];                        // [R16]
    st_d.ss_n = st_q.dir[`GPA_PIN_SS] ?
                pin_sync[`GPA_PIN_SS] : 1'b1;                   // [R17]
  end

  // Reset leaves analog pins analog and every pin an input [R8]
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q          <= '0;
      st_q.lat      <= `GPA_RST_LAT;
      st_q.dir      <= `GPA_RST_DIR;
      st_q.ans      <= `GPA_RST_ANS;                            // [R7]
      st_q.pctl     <= `GPA_RST_PCTL;
      st_q.osc      <= GPA_OSC_LP;
      st_q.div      <= `GPA_RST_DIV;
      st_q.pad_oe_n <= 8'hff;
      st_q.ss_n     <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign reg_rdata           = st_q.rdata;
  assign pad_out             = st_q.pad_out;
  assign pad_oe_n            = st_q.pad_oe_n;
  assign timer0_ext_clock_in = st_q.t0ck;
  assign ssp_select_n        = st_q.ss_n;

  // Checks on the port behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_dir_input_off: assert property ( // [R1]
    st_q.dir[0] |=> pad_oe_n[0])
    else $error("input pin 0 still driven");

  chk_dir_output_drive: assert property ( // [R2]
    !st_q.dir[1] && !st_q.pctl[`GPA_PCTL_CVROE]
    |=> !pad_oe_n[1] && pad_out[1] == $past(st_q.lat[1]))
    else $error("output pin 1 not driven from latch");

  chk_level_write_latch: assert property ( // [R3]
    reg_wr && reg_addr == `GPA_OFS_LEVEL
    |=> st_q.lat == $past(reg_wdata))
    else $error("pin-level write missed the latch");

  chk_latch_readback: assert property ( // [R4]
    reg_rd && reg_addr == `GPA_OFS_LATCH
    |=> reg_rdata[5:0] == $past(st_q.lat[5:0])
    ##1 ($past(reg_rd) || reg_rdata == 8'h00))
    else $error("latch readback wrong");

  chk_osc_bits_zero: assert property ( // [R6]
    reg_rd && reg_addr == `GPA_OFS_DIR && !io7
    |=> reg_rdata[7] == 1'b0)
    else $error("oscillator bit 7 direction not zero");

  chk_analog_reset: assert property ( // [R7]
    @(posedge mclk) $fell(sys_rst) |-> st_q.ans == `GPA_RST_ANS)
    else $error("analog select not all set after reset");

  chk_analog_reads_zero: assert property ( // [R9]
    reg_rd && reg_addr == `GPA_OFS_LEVEL && st_q.ans[0]
    |=> reg_rdata[0] == 1'b0)
    else $error("analog pin 0 read non-zero");

  chk_cmp_override: assert property ( // [R11]
    st_q.pctl[`GPA_PCTL_C1OE] && !st_q.dir[4]
    |=> pad_out[4] == $past(comparator_one_output) && !pad_oe_n[4])
    else $error("comparator 1 output not on pin 4");

  chk_comparator_ref_voltage_out_kill: assert property ( // [R12]
    st_q.pctl[`GPA_PCTL_CVROE] |=> pad_oe_n[2])
    else $error("pin 2 driven with reference output on");

  chk_clkout_period: assert property ( // [R14]
    clkout6 && $rose(pad_out[6]) |-> ##1 pad_out[6] ##1 !pad_out[6]
    ##1 !pad_out[6] ##1 pad_out[6])
    else $error("clock out not a quarter of mclk");

  chk_timer_feed: assert property ( // [R16]
    st_q.dir[4] |=> timer0_ext_clock_in == $past(pin_sync[4]))
    else $error("timer0 clock not following pin 4");

  chk_select_feed: assert property ( // [R17]
    !st_q.dir[5] |=> ssp_select_n)
    else $error("slave select active with pin 5 an output");

  cov_latch_write_read: cover property (
    reg_wr && reg_addr == `GPA_OFS_LATCH
    ##1 reg_rd && reg_addr == `GPA_OFS_LATCH);
  cov_digital_level_read: cover property (
    reg_rd && reg_addr == `GPA_OFS_LEVEL && st_q.ans == 5'h00);
  cov_cmp_two_out: cover property (
    st_q.pctl[`GPA_PCTL_C2OE] && !st_q.dir[5]);
  cov_clkout_running: cover property (clkout6 && $rose(pad_out[6]));
endmodule // gpa_port

// [verification/gpa_board.sv]
`timescale 1ns/10ps
module gpa_board (
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] ext_lvl,
  output logic      [7:0] pad_in
);
  // Driven pins echo the port; released pins fall to the board level,
  // so a stale port value can never be mistaken for a pin level
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pad_in[i] = pad_oe_n[i] ? ext_lvl[i] : pad_out[i];
  end
endmodule // gpa_board

// [verification/tb_gpa_port.sv]
`timescale 1ns/10ps
`include "gpa_params.svh"
module tb_gpa_port;
  import gpa_pkg::*;
  logic                   mclk      = 1'b0;
  logic                   sys_rst   = 1'b1;
  logic [`GPA_ADDR_W-1:0] reg_addr  = '0;
  logic [7:0]             reg_wdata = 8'h00;
  logic                   reg_wr    = 1'b0;
  logic                   reg_rd    = 1'b0;
  logic [7:0]             reg_rdata;
  gpa_osc_mode_t          osc_cfg   = GPA_OSC_LP;
  logic                   cmp1      = 1'b0;
  logic                   cmp2      = 1'b0;
  logic [7:0]             ext_lvl   = 8'hff;
  logic [7:0]             pad_in;
  logic [7:0]             pad_out;
  logic [7:0]             pad_oe_n;
  logic                   t0ck;
  logic                   ss_n;
  logic [8:0]             smp;
  logic                   io6, io7, ck6;
  int                     ones, flips;
  int                     error_cnt   = 0;
  int                     comparisons = 0;

  // 100 MHz system clock
  always #5 mclk = ~mclk;

  gpa_port uut (
    .mclk                  (mclk),
    .sys_rst               (sys_rst),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata             (reg_rdata),
    .osc_cfg               (osc_cfg),
    .comparator_one_output (cmp1),
    .comparator_two_output (cmp2),
    .pad_in                (pad_in),
    .pad_out               (pad_out),
    .pad_oe_n              (pad_oe_n),
    .timer0_ext_clock_in   (t0ck),
    .ssp_select_n          (ss_n)
  );

  gpa_board board (
    .pad_out  (pad_out),
    .pad_oe_n (pad_oe_n),
    .ext_lvl  (ext_lvl),
    .pad_in   (pad_in)
  );

  // Verdict, shared by the main sequence and the watchdog
  task automatic test_done();
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Bus cycles; strobes change only right after a rising edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // Covers driver update plus the two input sync stages
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Oscillator choice is captured at the first edge after release
  task automatic rst(input logic [3:0] m);
    @(posedge mclk);
    sys_rst <= 1'b1;
    osc_cfg <= gpa_osc_mode_t'(m);
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask

  // Watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    test_done();
  end

  initial
  begin
    rst(4'h0);
    rd(`GPA_OFS_LATCH, 8'h00);
    rd(`GPA_OFS_DIR, 8'h3f);
    rd(`GPA_OFS_ANALOG_SELECT_REG, 8'h1f);
    rd(`GPA_OFS_LEVEL, 8'h10);
    chk(pad_oe_n, 8'hff);
    // Digital inputs and the shared timer and select paths
    ext_lvl <= 8'ha5;
    wr(`GPA_OFS_ANALOG_SELECT_REG, 8'h00);
    idle(4);
    rd(`GPA_OFS_LEVEL, 8'h25);
    chk({6'h0, t0ck, ss_n}, 8'h01);
    ext_lvl <= 8'h5a;
    idle(4);
    chk({6'h0, t0ck, ss_n}, 8'h02);
    // Pin-level writes land in the latch; reads keep seeing pins
    wr(`GPA_OFS_LEVEL, 8'h3c);
    rd(`GPA_OFS_LATCH, 8'h3c);
    rd(`GPA_OFS_LEVEL, 8'h5a & 8'h3f);
    wr(`GPA_OFS_DIR, 8'hf0);
    idle(2);
    chk(pad_oe_n, 8'hf0);
    chk({4'h0, pad_out[3:0]}, 8'h0c);
    rd(`GPA_OFS_LEVEL, 8'h1c);
    rd(`GPA_OFS_DIR, 8'h30);
    // Analog select blanks reads but leaves drivers alone
    wr(`GPA_OFS_ANALOG_SELECT_REG, 8'h1f);
    idle(3);
    chk(pad_oe_n, 8'hf0);
    rd(`GPA_OFS_LEVEL, 8'h10);
    wr(`GPA_OFS_ANALOG_SELECT_REG, 8'h00);
    wr(`GPA_OFS_DIR, 8'hff);
    // Comparator outputs take pins four and five from the latch
    wr(`GPA_OFS_LATCH, 8'h00);
    wr(`GPA_OFS_DIR, 8'hcf);
    wr(`GPA_OFS_PCTL, 8'h03);
    rd(`GPA_OFS_PCTL, 8'h03);
    cmp1 <= 1'b1;
    idle(3);
    chk({6'h0, pad_out[5:4]}, 8'h01);
    chk({6'h0, t0ck, ss_n}, 8'h01);
    cmp1 <= 1'b0;
    cmp2 <= 1'b1;
    idle(3);
    chk({6'h0, pad_out[5:4]}, 8'h02);
    wr(`GPA_OFS_PCTL, 8'h00);
    idle(2);
    chk({6'h0, pad_out[5:4]}, 8'h00);
    // Reference output kills digital use of pin two
    wr(`GPA_OFS_PCTL, 8'h04);
    wr(`GPA_OFS_DIR, 8'hfb);
    ext_lvl <= 8'hff;
    idle(4);
    chk(pad_oe_n, 8'hff);
    rd(`GPA_OFS_LEVEL, 8'h3b);
    // Unmapped places are ignored and read zero
    wr(3'h6, 8'h55);
    rd(3'h5, 8'h00);
    rd(`GPA_OFS_LATCH, 8'h00);
    // Every oscillator selection, pins six and seven
    for (int m = 0; m < 9; m++)
    begin
      io6 = (m == 4 || m == 6 || m == 8);
      ck6 = (m == 3 || m == 5 || m == 7);
      io7 = (m == 5 || m == 6);
      rst(m[3:0]);
      wr(`GPA_OFS_DIR, 8'h00);
      wr(`GPA_OFS_LATCH, 8'hff);
      idle(3);
      chk({6'h0, pad_oe_n[7:6]}, {6'h0, !io7, !(io6 || ck6)});
      rd(`GPA_OFS_LATCH, {io7, io6, 6'h3f});
      wr(`GPA_OFS_DIR, 8'hff);
      idle(2);
      chk({7'h0, pad_oe_n[6]}, {7'h0, !ck6});
      for (int i = 0; i < 9; i++)
      begin
        idle(1);
        smp[i] = pad_out[6];
      end
      ones = 0;
      flips = 0;
      for (int i = 0; i < 8; i++)
      begin
        ones += smp[i];
        flips += (smp[i] != smp[i+1]);
      end
      if (ck6)
        chk(8'(ones * 16 + flips), 8'h44);
    end
    test_done();
  end
endmodule // tb_gpa_port
